// file: rtl/sam_params.svh
`ifndef SAM_PARAMS_SVH
`define SAM_PARAMS_SVH

// Register indices; byte address is four times the index
`define SAM_IDX_SYS_EN      8'h5E
`define SAM_IDX_MON_EV      8'h5F
`define SAM_IDX_SYS_TIME    8'h63
`define SAM_IDX_IO10_LO     8'h66
`define SAM_IDX_IO10_HI     8'h67
`define SAM_IDX_IO16_LO     8'h6D
`define SAM_IDX_IO16_HI     8'h6E
`define SAM_IDX_MON_TIME    8'h70
`define SAM_IDX_CTRL        8'h71
`define SAM_IDX_STATE       8'h72
`define SAM_IDX_INT_STAT    8'h73
`define SAM_IDX_INT_MASK    8'h74

// Event enable bit positions
`define SAM_SYS_IO10        7
`define SAM_SYS_IO16        6
`define SAM_SYS_DISK        5
`define SAM_SYS_SERIAL      4
`define SAM_SYS_PAR         3
`define SAM_SYS_HOLD        2
`define SAM_SYS_IRQ         1
`define SAM_MON_RLD_IRQ     7
`define SAM_MON_RLD_HOLD    6
`define SAM_MON_WAKE_IRQ    5
`define SAM_MON_WAKE_HOLD   4
`define SAM_MON_GO_IRQ      3
`define SAM_MON_GO_HOLD     2
`define SAM_MON_GO_INIT     1
`define SAM_MON_RSVD        0

// Interrupt status bit positions
`define SAM_INT_SYS_SB      0
`define SAM_INT_MON_SB      1
`define SAM_INT_WAKE        2
`define SAM_INT_GO          3

`define SAM_RST_BYTE        8'h00
`define SAM_RST_ADDR        16'h0000

// Countdown tick
`define SAM_CLK_MHZ         40
`define SAM_TICK_US         1
`define SAM_TICK_CYC        (`SAM_TICK_US * `SAM_CLK_MHZ)

`endif

// file: rtl/sam_pkg.sv
package sam_pkg;

   typedef struct packed {
      logic io10;
      logic io16;
      logic disk;
      logic serial;
      logic par;
      logic hold;
      logic irq;
      logic init;
   } sam_evt_t;

   typedef enum logic [0:0] {
      SAM_RUN     = 1'b0,
      SAM_STANDBY = 1'b1
   } sam_pwr_t;

endpackage : sam_pkg

// file: rtl/sam_top.sv
// What this block does
// - Any enabled system event before expiry reloads the system countdown and restarts it.
// - System enable bit 7 lets the programmable 10-bit I/O address reload.
// - System enable bit 6 lets the programmable 16-bit I/O address reload.
// - System enable bit 5 lets hard disk ports 1F0-1F7h, 3F6h reload.
// - System enable bit 4 lets the four serial port ranges reload.
// - System enable bit 3 lets the three parallel port ranges reload.
// - System enable bit 2 lets ISA or PCI master requests reload.
// - System enable bit 1 lets interrupt lines 1-15 or NMI reload.
// - Monitor register bits 7:6 pick reload events, bits 5:1 pick break events.
// - Monitor bit 7 lets interrupts or NMI reload the monitor countdown.
// - Monitor bit 6 lets master requests reload the monitor countdown.
// - Monitor bit 5 lets interrupts or NMI end monitor standby.
// - Monitor bit 4 lets master requests end monitor standby.
// - Monitor bit 3 lets interrupts or NMI withdraw the halt request.
// - Monitor bit 2 lets master requests withdraw the halt request.
// - Monitor bit 1 lets soft init withdraw the halt request; bit 0 reserved zero.
// - System countdown expiry enters system standby until a wake event enabled by monitor bit 5 or 4.
//
// Design decision made here: the Wishbone register port.
`include "sam_params.svh"

module sam_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        io_access_i,
   input  wire logic [15:0] io_addr_i,
   input  wire logic        isa_master_req_i,
   input  wire logic        pci_master_req_i,
   input  wire logic [15:1] irq_i,
   input  wire logic        nmi_i,
   input  wire logic        soft_init_i,
   output logic             sys_standby_o,
   output logic             mon_standby_o,
   output logic             cpu_clock_halt_request_o,
   output logic             irq_o
);

   localparam int TICK_W = 6;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(`SAM_TICK_CYC - 1);

   // Two-flop synchronisers for all pin inputs
   logic [35:0] sync;
   logic [35:0] rise;

   sam_sync #(
      .W(36)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   ({io_access_i, io_addr_i, isa_master_req_i, pci_master_req_i,
                 irq_i, nmi_i, soft_init_i}),
      .level_o (sync),
      .rise_o  (rise)
   );

   logic [15:0] io_addr;
   logic        io_rise;
   logic        hold_rise;
   logic        irq_rise;
   logic        init_rise;

   assign io_addr   = sync[34:19];
   assign io_rise   = rise[35];
   assign hold_rise = |rise[18:17];
   assign irq_rise  = |rise[16:1];
   assign init_rise = rise[0];

   // Registers
   logic [7:0]  sys_en;
   logic [7:0]  mon_ev;
   logic [7:0]  sys_time;
   logic [7:0]  mon_time;
   logic [15:0] io10_addr;
   logic [15:0] io16_addr;
   logic [7:0]  int_stat;
   logic [7:0]  int_mask;

   // Event decode
   sam_pkg::sam_evt_t evt;

   always_comb begin
      evt        = '0;
      evt.io10   = io_rise && io_addr[9:0] == io10_addr[9:0];
      evt.io16   = io_rise && io_addr == io16_addr;
      evt.disk   = io_rise && (io_addr[9:3] == 7'h3E
                   || io_addr[9:0] == 10'h3F6);
      evt.serial = io_rise && (io_addr[9:3] == 7'h5F
                   || io_addr[9:3] == 7'h7F
                   || io_addr[9:3] == 7'h5D
                   || io_addr[9:3] == 7'h7D);
      evt.par    = io_rise && (io_addr[9:3] == 7'h4F
                   || io_addr[9:3] == 7'h6F
                   || (io_addr[9:2] == 8'hEF
                       && io_addr[1:0] != 2'h3));
      evt.hold   = hold_rise;
      evt.irq    = irq_rise;
      evt.init   = init_rise;
   end

   logic sys_reload;
   logic mon_reload;
   logic wake;
   logic halt_off;

   assign sys_reload = (sys_en[`SAM_SYS_IO10] & evt.io10)
                     | (sys_en[`SAM_SYS_IO16] & evt.io16)
                     | (sys_en[`SAM_SYS_DISK] & evt.disk)
                     | (sys_en[`SAM_SYS_SERIAL] & evt.serial)
                     | (sys_en[`SAM_SYS_PAR] & evt.par)
                     | (sys_en[`SAM_SYS_HOLD] & evt.hold)
                     | (sys_en[`SAM_SYS_IRQ] & evt.irq);

   assign mon_reload = (mon_ev[`SAM_MON_RLD_IRQ] & evt.irq)
                     | (mon_ev[`SAM_MON_RLD_HOLD] & evt.hold);

   assign wake = (mon_ev[`SAM_MON_WAKE_IRQ] & evt.irq)
               | (mon_ev[`SAM_MON_WAKE_HOLD] & evt.hold);

   assign halt_off = (mon_ev[`SAM_MON_GO_IRQ] & evt.irq)
                   | (mon_ev[`SAM_MON_GO_HOLD] & evt.hold)
                   | (mon_ev[`SAM_MON_GO_INIT] & evt.init);

   // Bus decode
   logic       wb_req;
   logic       wr;
   logic [7:0] idx;
   logic [7:0] wdat;

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr     = wb_req & wb_we_i & wb_sel_i[0];
   assign idx    = wb_adr_i[9:2];
   assign wdat   = wb_dat_i[7:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_en    <= `SAM_RST_BYTE;
         mon_ev    <= `SAM_RST_BYTE;
         sys_time  <= `SAM_RST_BYTE;
         mon_time  <= `SAM_RST_BYTE;
         io10_addr <= `SAM_RST_ADDR;
         io16_addr <= `SAM_RST_ADDR;
         int_mask  <= `SAM_RST_BYTE;
      end else if (wr) begin
         case (idx)
            `SAM_IDX_SYS_EN:   sys_en <= wdat;
            `SAM_IDX_MON_EV:   mon_ev <= {wdat[7:1], 1'b0};
            `SAM_IDX_SYS_TIME: sys_time <= wdat;
            `SAM_IDX_MON_TIME: mon_time <= wdat;
            `SAM_IDX_IO10_LO:  io10_addr[7:0] <= wdat;
            `SAM_IDX_IO10_HI:  io10_addr[15:8] <= {6'h00, wdat[1:0]};
            `SAM_IDX_IO16_LO:  io16_addr[7:0] <= wdat;
            `SAM_IDX_IO16_HI:  io16_addr[15:8] <= wdat;
            `SAM_IDX_INT_MASK: int_mask <= {4'h0, wdat[3:0]};
            default: ;
         endcase
      end
   end

   // Shared countdown tick
   logic [TICK_W-1:0] tick_cnt;
   logic              tick;

   assign tick = tick_cnt == TICK_LAST;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + TICK_W'(1);
      end
   end

   // System standby countdown
   logic [7:0]        sys_cnt;
   sam_pkg::sam_pwr_t sys_state;
   logic              sys_expire;

   assign sys_expire = sys_state == sam_pkg::SAM_RUN && tick
                       && sys_cnt == 8'h01 && !sys_reload;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_cnt <= 8'h00;
      end else if (sys_reload || (sys_state == sam_pkg::SAM_STANDBY && wake)) begin
         sys_cnt <= sys_time;
      end else if (tick && sys_cnt != 8'h00) begin
         sys_cnt <= sys_cnt - 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_state <= sam_pkg::SAM_RUN;
      end else begin
         case (sys_state)
            sam_pkg::SAM_RUN:
               if (sys_expire) begin
                  sys_state <= sam_pkg::SAM_STANDBY;
               end
            sam_pkg::SAM_STANDBY:
               if (wake) begin
                  sys_state <= sam_pkg::SAM_RUN;
               end
            default: sys_state <= sam_pkg::SAM_RUN;
         endcase
      end
   end

   // Monitor standby countdown
   logic [7:0]        mon_cnt;
   sam_pkg::sam_pwr_t mon_state;
   logic              mon_expire;

   assign mon_expire = mon_state == sam_pkg::SAM_RUN && tick
                       && mon_cnt == 8'h01 && !mon_reload;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mon_cnt <= 8'h00;
      end else if (mon_reload || (mon_state == sam_pkg::SAM_STANDBY && wake)) begin
         mon_cnt <= mon_time;
      end else if (tick && mon_cnt != 8'h00) begin
         mon_cnt <= mon_cnt - 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mon_state <= sam_pkg::SAM_RUN;
      end else begin
         case (mon_state)
            sam_pkg::SAM_RUN:
               if (mon_expire) begin
                  mon_state <= sam_pkg::SAM_STANDBY;
               end
            sam_pkg::SAM_STANDBY:
               if (wake) begin
                  mon_state <= sam_pkg::SAM_RUN;
               end
            default: mon_state <= sam_pkg::SAM_RUN;
         endcase
      end
   end

   // Halt request: software sets, events withdraw
   logic halt_set;

   assign halt_set = wr && idx == `SAM_IDX_CTRL && wdat[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_clock_halt_request_o <= 1'b0;
      end else if (halt_off) begin
         cpu_clock_halt_request_o <= 1'b0;
      end else if (halt_set) begin
         cpu_clock_halt_request_o <= 1'b1;
      end
   end

   // Interrupt status, write one to clear, set wins
   logic [7:0] int_set;
   logic [7:0] int_clr;

   always_comb begin
      int_set                  = 8'h00;
      int_set[`SAM_INT_SYS_SB] = sys_expire;
      int_set[`SAM_INT_MON_SB] = mon_expire;
      int_set[`SAM_INT_WAKE]   = wake && (sys_state == sam_pkg::SAM_STANDBY
                                 || mon_state == sam_pkg::SAM_STANDBY);
      int_set[`SAM_INT_GO]     = halt_off && cpu_clock_halt_request_o;
      int_clr                  = (wr && idx == `SAM_IDX_INT_STAT) ? wdat : 8'h00;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_stat <= `SAM_RST_BYTE;
      end else begin
         int_stat <= (int_stat & ~int_clr) | int_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(((int_stat & ~int_clr) | int_set) & int_mask);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_standby_o <= 1'b0;
         mon_standby_o <= 1'b0;
      end else begin
         sys_standby_o <= sys_state == sam_pkg::SAM_STANDBY;
         mon_standby_o <= mon_state == sam_pkg::SAM_STANDBY;
      end
   end

   // Wishbone read and ack
   logic [7:0] rdat;

   always_comb begin
      case (idx)
         `SAM_IDX_SYS_EN:   rdat = sys_en;
         `SAM_IDX_MON_EV:   rdat = mon_ev;
         `SAM_IDX_SYS_TIME: rdat = sys_time;
         `SAM_IDX_MON_TIME: rdat = mon_time;
         `SAM_IDX_IO10_LO:  rdat = io10_addr[7:0];
         `SAM_IDX_IO10_HI:  rdat = io10_addr[15:8];
         `SAM_IDX_IO16_LO:  rdat = io16_addr[7:0];
         `SAM_IDX_IO16_HI:  rdat = io16_addr[15:8];
         `SAM_IDX_CTRL:     rdat = {7'h00, cpu_clock_halt_request_o};
         `SAM_IDX_STATE:    rdat = {6'h00, mon_state == sam_pkg::SAM_STANDBY,
                                    sys_state == sam_pkg::SAM_STANDBY};
         `SAM_IDX_INT_STAT: rdat = int_stat;
         `SAM_IDX_INT_MASK: rdat = int_mask;
         default:           rdat = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? {24'h000000, rdat} : 32'h00000000;
      end
   end

endmodule : sam_top

// Two-flop synchroniser with a rising-edge detector behind it
module sam_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o,
   output logic      [W-1:0] rise_o
);

   logic [W-1:0] meta;
   logic [W-1:0] sync;
   logic [W-1:0] sync_d;

   // First stage read by the second stage only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= '0;
         sync <= '0;
      end else begin
         meta <= pin_i;
         sync <= meta;
      end
   end

   // Previous level, idle low after reset like the pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_d <= '0;
      end else begin
         sync_d <= sync;
      end
   end

   assign level_o = sync;
   assign rise_o  = sync & ~sync_d;

endmodule : sam_sync

// file: dv/sam_chk.sv
`include "sam_params.svh"

module sam_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [9:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        isa_master_req_i,
   input wire logic        pci_master_req_i,
   input wire logic [15:1] irq_i,
   input wire logic        nmi_i,
   input wire logic        soft_init_i,
   input wire logic        sys_standby_o,
   input wire logic        mon_standby_o,
   input wire logic        cpu_clock_halt_request_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mon;
   wire        hold_ev = isa_master_req_i || pci_master_req_i;
   wire        irq_ev  = nmi_i || (|irq_i);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Shadow of the monitor event register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mon <= 8'h00;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                   && wb_adr_i[9:2] == `SAM_IDX_MON_EV) begin
         mon <= wb_dat_i[7:0];
      end
   end

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_dat_byte: assert property (wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_irq_go: assert property ($rose(irq_ev) && mon[3] |->
      ##[1:6] !cpu_clock_halt_request_o)
      else $error("interrupt kept halt request");
   a_hold_go: assert property ($rose(hold_ev) && mon[2] |->
      ##[1:6] !cpu_clock_halt_request_o)
      else $error("master request kept halt request");
   a_init_go: assert property ($rose(soft_init_i) && mon[1] |->
      ##[1:6] !cpu_clock_halt_request_o)
      else $error("soft init kept halt request");
   a_irq_wake: assert property ($rose(irq_ev) && mon[5] |-> ##[1:6] !mon_standby_o)
      else $error("interrupt did not end monitor standby");
   a_hold_wake: assert property ($rose(hold_ev) && mon[4] |->
      ##[1:6] !mon_standby_o && !sys_standby_o)
      else $error("master request did not end standby");
endmodule : sam_chk

bind sam_top sam_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .isa_master_req_i(isa_master_req_i),
   .pci_master_req_i(pci_master_req_i), .irq_i(irq_i), .nmi_i(nmi_i),
   .soft_init_i(soft_init_i), .sys_standby_o(sys_standby_o), .mon_standby_o(mon_standby_o),
   .cpu_clock_halt_request_o(cpu_clock_halt_request_o)
);

// file: dv/sam_src.sv
module sam_src (
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic [2:0]  kind_i,
   input  wire logic [15:0] addr_i,
   output logic             io_access_o,
   output logic [15:0]      io_addr_o,
   output logic             isa_o,
   output logic             pci_o,
   output logic [15:1]      irq_o,
   output logic             nmi_o,
   output logic             init_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt = 4'h0;
   logic [2:0] k   = 3'h0;
   wire        act = cnt > 4'h4 && cnt < 4'h9;

   initial io_addr_o = 16'h0000;
   // Address held well past the strobe, then scrambled
   always @(posedge clk_i) begin
      if (go_i) begin
         k <= kind_i;
         cnt <= 4'h9;
         io_addr_o <= addr_i;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h1) begin
            io_addr_o <= ~io_addr_o;
         end
      end
   end
   assign io_access_o = act && k == 3'h0;
   assign isa_o = act && k == 3'h1;
   assign pci_o = act && k == 3'h2;
   assign irq_o = {act && k == 3'h3, 14'h0};
   assign nmi_o = act && k == 3'h4;
   assign init_o = act && k == 3'h5;
endmodule : sam_src

// file: dv/sam_top_tb.sv
module sam_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [9:0]  adr = 10'h000;
   logic [31:0] wdat = 32'h0;
   logic        go = 1'b0;
   logic [2:0]  kind = 3'h0;
   logic [15:0] addr = 16'h0;
   logic [31:0] rdat;
   logic [15:0] io_adr;
   logic [15:1] irq;
   logic        ack, io_acc, isa, pci, nmi, init, sys_sb, mon_sb, halt, int_o;
   int          errors = 0;
   int          total_checks = 0;
   int          cycles = 0;

   sam_top u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .io_access_i(io_acc), .io_addr_i(io_adr), .isa_master_req_i(isa),
      .pci_master_req_i(pci), .irq_i(irq), .nmi_i(nmi), .soft_init_i(init),
      .sys_standby_o(sys_sb), .mon_standby_o(mon_sb), .cpu_clock_halt_request_o(halt),
      .irq_o(int_o)
   );
   sam_src u_src (
      .clk_i(clk_i), .go_i(go), .kind_i(kind), .addr_i(addr), .io_access_o(io_acc),
      .io_addr_o(io_adr), .isa_o(isa), .pci_o(pci), .irq_o(irq), .nmi_o(nmi), .init_o(init)
   );

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         complete_run();
      end
   end

   task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d,
                     output logic [7:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h0, d};
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, i, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] i, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, i, 8'h00, q);
      chk("reg", q, e);
   endtask : rd

   task automatic fire(input logic [2:0] k, input logic [15:0] a);
      @(posedge clk_i);
      go <= 1'b1;
      kind <= k;
      addr <= a;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (14) @(posedge clk_i);
   endtask : fire

   task automatic t_regs();
      rd(8'h5E, 8'h00);
      rd(8'h5F, 8'h00);
      wr(8'h5F, 8'hFF);
      rd(8'h5F, 8'hFE);
      wr(8'h10, 8'h5A);
      rd(8'h10, 8'h00);
      wr(8'h66, 8'h34);
      wr(8'h67, 8'hFE);
      rd(8'h67, 8'h02);
      wr(8'h6D, 8'h12);
      wr(8'h6E, 8'h5A);
      rd(8'h6E, 8'h5A);
   endtask : t_regs

   task automatic t_sys(input int b, input logic [2:0] k, input logic [15:0] a);
      wr(8'h74, 8'hF1);
      rd(8'h74, 8'h01);
      wr(8'h5F, 8'h10);
      wr(8'h63, 8'h01);
      wr(8'h5E, ~(8'h01 << b) & 8'hFE);
      fire(k, a);
      repeat (100) @(posedge clk_i);
      chk("sys_off", sys_sb, 1'b0);
      wr(8'h5E, 8'h01 << b);
      fire(k, a);
      repeat (200) if (sys_sb !== 1'b1) @(posedge clk_i);
      @(posedge clk_i);
      chk("sys_on", sys_sb, 1'b1);
      chk("irq_on", int_o, 1'b1);
      rd(8'h72, 8'h01);
      wr(8'h63, 8'h00);
      fire(3'h1, 16'h0);
      chk("sys_wake", sys_sb, 1'b0);
      wr(8'h73, 8'h0F);
      @(posedge clk_i);
      chk("irq_off", int_o, 1'b0);
   endtask : t_sys

   // Second event mid-count must push expiry out past the first deadline
   task automatic t_restart();
      wr(8'h5E, 8'h04);
      wr(8'h5F, 8'h00);
      wr(8'h63, 8'h03);
      fire(3'h2, 16'h0);
      repeat (45) @(posedge clk_i);
      fire(3'h2, 16'h0);
      repeat (59) @(posedge clk_i);
      chk("sys_hold", sys_sb, 1'b0);
      repeat (200) if (sys_sb !== 1'b1) @(posedge clk_i);
      chk("sys_late", sys_sb, 1'b1);
      wr(8'h63, 8'h00);
      wr(8'h5F, 8'h10);
      fire(3'h1, 16'h0);
      chk("sys_back", sys_sb, 1'b0);
   endtask : t_restart

   task automatic t_mon(input logic [7:0] en, input logic [2:0] rk, input logic [2:0] wk);
      wr(8'h5F, en);
      wr(8'h70, 8'h01);
      fire(rk, 16'h0);
      repeat (200) if (mon_sb !== 1'b1) @(posedge clk_i);
      chk("mon_on", mon_sb, 1'b1);
      wr(8'h70, 8'h00);
      fire(wk, 16'h0);
      chk("mon_wake", mon_sb, 1'b0);
   endtask : t_mon

   task automatic t_halt(input int b, input logic [2:0] k);
      wr(8'h5F, 8'h01 << b);
      wr(8'h71, 8'h01);
      rd(8'h71, 8'h01);
      chk("halt_on", halt, 1'b1);
      wr(8'h73, 8'h0F);
      fire(k, 16'h0);
      chk("halt_off", halt, 1'b0);
      rd(8'h73, 8'h08);
      chk("irq_mask", int_o, 1'b0);
   endtask : t_halt

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_sys(7, 3'h0, 16'hA234);
      t_sys(6, 3'h0, 16'h5A12);
      t_sys(5, 3'h0, 16'h03F6);
      t_sys(4, 3'h0, 16'h02EF);
      t_sys(3, 3'h0, 16'h03BE);
      t_sys(2, 3'h2, 16'h0000);
      t_sys(1, 3'h4, 16'h0000);
      t_restart();
      t_mon(8'h90, 3'h3, 3'h1);
      t_mon(8'h60, 3'h2, 3'h4);
      t_halt(3, 3'h3);
      t_halt(2, 3'h2);
      t_halt(1, 3'h5);
      complete_run();
   end
endmodule : sam_top_tb
